// ---- hdl/sync_serial_pkg.sv ----
// Shared constants, carriers and types for the synchronous serial block
package sync_serial_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite port)
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;  // Control bits
    localparam logic [7:0]  ADDR_STATUS = 8'h04;  // Status, read only
    localparam logic [7:0]  ADDR_RXDATA = 8'h08;  // Received data, pops
    localparam logic [7:0]  ADDR_TXDATA = 8'h0c;  // Transmit data, write
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Character and FIFO sizes
    // ------------------------------------------------------------------
    localparam logic [3:0]  BITS_8      = 4'h8;   // Plain character
    localparam logic [3:0]  BITS_9      = 4'h9;   // Character with bit 9
    localparam logic [1:0]  FIFO_DEPTH  = 2'h2;   // Receive FIFO words

    // ------------------------------------------------------------------
    // Timing: master shift clock half period
    // ------------------------------------------------------------------
    localparam int          CLK_NS      = 10;     // System clock period
    localparam int          HALF_NS     = 60;     // Master clock half
    localparam logic [7:0]  HALF_CYC    =
        8'((HALF_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Control register, bit 31 downward
    typedef struct packed {
        logic [19:0] unused;                       // Reads as zero
        logic        sleep_mode;                   // Bit 11
        logic        transmit_interrupt_enable;    // Bit 10
        logic        receive_interrupt_enable;     // Bit 9
        logic        transmit_ninth_bit;           // Bit 8
        logic        ninth_bit_transmit_enable;    // Bit 7
        logic        transmit_enable;              // Bit 6
        logic        ninth_bit_receive_enable;     // Bit 5
        logic        continuous_receive_enable;    // Bit 4
        logic        single_receive_enable;        // Bit 3
        logic        clock_source_select;          // Bit 2
        logic        mode_select;                  // Bit 1
        logic        serial_port_enable;           // Bit 0
    } ctrl_t;

    // Pins sampled from outside
    typedef struct packed {
        logic shift_clock_pin;                     // Clock line level
        logic serial_data_pin;                     // Data line level
    } pins_in_t;

    // Pin drive and enables
    typedef struct packed {
        logic shift_clock_out;
        logic shift_clock_oe;
        logic serial_data_out;
        logic serial_data_oe;
    } pins_out_t;

    // Operating mode of the port
    typedef enum logic [1:0] {
        MODE_OFF       = 2'b00,
        MODE_MASTER_RX = 2'b01,
        MODE_SLAVE_RX  = 2'b10,
        MODE_SLAVE_TX  = 2'b11
    } mode_t;
endpackage

// ---- hdl/sync_serial_rx_slave_sleep.sv ----
// Synchronous serial port: master/slave receive, slave transmit, sleep
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Two-deep receive FIFO; third character sets overrun
// - Overrun keeps FIFO; no more characters accepted
// - Single-mode overrun clears on received-data read
// - Continuous-mode overrun clears by disabling receive/port
// - Nine-bit reception shifts nine bits per character
// - Ninth-bit status shows oldest unread character
// - Completed character sets receive flag, interrupt
// - Slave takes clock from pin, driver off
// - Data changes leading edge, valid trailing
// - Slave mode: sync, clock source 0, enabled
// - Both receive enables clear means transmit
// - Slave receive always continuous; single alone only makes overrun clear on read
// - Slave transmit shifts only on master clocks
// - Second word held, transmit flag stays clear
// - Word done: held byte loads, flag sets
// - Writing transmit data clears transmit flag only while shift register busy
// - Only slave mode shifts during sleep
// - Slave receive in sleep sets flag, wakes
// - Receive flag set while FIFO unread
// - Master single receive self-clears; continuous wins
// - Data sampled on trailing clock edge
module sync_serial_rx_slave_sleep (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [sync_serial_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [sync_serial_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire sync_serial_pkg::pins_in_t       pins_i,
    output sync_serial_pkg::pins_out_t           pins_o,
    output logic                                 irq
);
    import sync_serial_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ctrl_t             ctrl;       // Software control bits
        logic              sck_s1;     // Clock synchroniser, first
        logic              sck_s2;     // Clock synchroniser, second
        logic              sck_s3;     // Previous level for edges
        logic              dat_s1;     // Data synchroniser, first
        logic              dat_s2;     // Data synchroniser, second
        logic              mclk;       // Master clock level
        logic [7:0]        mdiv;       // Master half period count
        logic [3:0]        rbits;      // Receive bit index
        logic [8:0]        receive_shift_register;        // Receive shift register
        logic [1:0][8:0]   fifo;       // Receive FIFO slots
        logic [1:0]        fcnt;       // Words held in FIFO
        logic              head;       // Oldest slot
        logic              overrun_error_flag;       // Overrun error flag
        logic              overrun_error_flag_single; // Overrun came in single mode
        logic [8:0]        transmit_shift_register;        // Transmit shift register
        logic              tsr_busy;   // Shift register loaded
        logic [3:0]        tbits;      // Bits driven so far
        logic [8:0]        hold;       // Transmit data register
        logic              hold_full;  // Held byte waiting
        logic              dout;       // Data pin drive
        logic              aw_full;    // Write address captured
        logic [7:0]        awaddr;
        logic              w_full;     // Write data captured
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              aw_rdy;
        logic              w_rdy;
        logic              ar_rdy;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        pins_out_t         pins;
        logic              irq;
    } state_t;

    state_t s;                         // Registered state
    state_t n;                         // Next state
    mode_t  mode;                      // Decoded operating mode
    logic   rx_done;                   // Character completed
    logic   pop;                       // Received-data read pops
    logic   tx_done;                   // Transmit word finished
    logic   wr_tx;                     // Transmit data write
    logic   lead;                      // Leading shift clock edge
    logic   trail;                     // Trailing shift clock edge

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic       wr_go;
        logic [3:0] rx_n;
        logic [3:0] tx_n;
        logic [8:0] ch;
        logic [7:0] wa;
        wr_go   = 1'b0;
        rx_n    = BITS_8;
        tx_n    = BITS_8;
        ch      = 9'h000;
        wa      = 8'h00;
        n       = s;
        rx_done = 1'b0;
        pop     = 1'b0;
        tx_done = 1'b0;
        wr_tx   = 1'b0;
        lead    = 1'b0;
        trail   = 1'b0;

        // Pin synchronisers; first flops feed only the second
        n.sck_s1 = pins_i.shift_clock_pin;
        n.sck_s2 = s.sck_s1;
        n.sck_s3 = s.sck_s2;
        n.dat_s1 = pins_i.serial_data_pin;
        n.dat_s2 = s.dat_s1;

        // Mode decode
        if (!s.ctrl.serial_port_enable || !s.ctrl.mode_select) begin
            mode = MODE_OFF;
        end else if (s.ctrl.clock_source_select) begin
            // Master only receives here; transmit direction idles
            mode = (s.ctrl.single_receive_enable ||
                    s.ctrl.continuous_receive_enable) ?
                   MODE_MASTER_RX : MODE_OFF;
        end else if (s.ctrl.single_receive_enable ||
                     s.ctrl.continuous_receive_enable) begin
            mode = MODE_SLAVE_RX;      // Single alone still runs
        end else begin
            mode = MODE_SLAVE_TX;
        end

        // Character lengths
        rx_n = s.ctrl.ninth_bit_receive_enable ? BITS_9 : BITS_8;
        tx_n = s.ctrl.ninth_bit_transmit_enable ? BITS_9 : BITS_8;

        // Shift clock edges
        case (mode)
            MODE_MASTER_RX: begin
                // Master clock stops in sleep or on overrun
                if (!s.ctrl.sleep_mode && !s.overrun_error_flag) begin
                    if (s.mdiv == HALF_CYC - 8'h01) begin
                        n.mdiv = 8'h00;
                        n.mclk = ~s.mclk;
                        lead   = ~s.mclk;
                        trail  = s.mclk;
                    end else begin
                        n.mdiv = s.mdiv + 8'h01;
                    end
                end
            end
            MODE_SLAVE_RX, MODE_SLAVE_TX: begin
                // Edges of the synchronised pin, once each
                lead   = s.sck_s2 & ~s.sck_s3;
                trail  = ~s.sck_s2 & s.sck_s3;
                n.mclk = 1'b0;
                n.mdiv = 8'h00;
            end
            default: begin
                n.mclk = 1'b0;
                n.mdiv = 8'h00;
            end
        endcase

        // Receive shifting; partial character dropped when idle
        if ((mode != MODE_MASTER_RX && mode != MODE_SLAVE_RX) ||
            s.overrun_error_flag) begin
            n.rbits = 4'h0;
        end else if (trail) begin
            // Sample data on trailing edge
            ch           = s.receive_shift_register;
            ch[s.rbits]  = s.dat_s2;
            n.receive_shift_register        = ch;
            if (s.rbits == rx_n - 4'h1) begin
                rx_done = 1'b1;
                n.rbits = 4'h0;
                if (!s.ctrl.ninth_bit_receive_enable) begin
                    ch[8] = 1'b0;
                end
            end else begin
                n.rbits = s.rbits + 4'h1;
            end
        end

        // Register bus: channel capture and response release
        if (s_axi_awvalid && s.aw_rdy) begin
            n.aw_full = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.w_rdy) begin
            n.w_full = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end

        // Read channel; received-data read pops the FIFO
        if (s_axi_arvalid && s.ar_rdy) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = ZERO_WORD;
            case (s_axi_araddr)
                ADDR_CTRL:   n.rdata = s.ctrl;
                ADDR_STATUS: n.rdata = {25'h0, s.fcnt, s.tsr_busy,
                                        ~s.hold_full, s.fcnt != 2'h0,
                                        s.fifo[s.head][8], s.overrun_error_flag};
                ADDR_RXDATA: begin
                    n.rdata = {24'h0, s.fifo[s.head][7:0]};
                    pop     = (s.fcnt != 2'h0);
                end
                default:     n.rresp = RESP_SLVERR;
            endcase
        end

        // Receive FIFO pop and push
        if (pop) begin
            n.head = ~s.head;
        end
        if (rx_done && s.fcnt == FIFO_DEPTH && !pop) begin
            // Third character: keep stored words
            n.overrun_error_flag        = 1'b1;
            n.overrun_error_flag_single = s.ctrl.single_receive_enable &
                            ~s.ctrl.continuous_receive_enable;
        end else if (rx_done) begin
            n.fifo[s.head ^ s.fcnt[0]] = ch;
        end
        n.fcnt = s.fcnt - {1'b0, pop} +
                 {1'b0, rx_done && !(s.fcnt == FIFO_DEPTH && !pop)};

        // Overrun clearing
        if (s.overrun_error_flag && s.overrun_error_flag_single && pop) begin
            n.overrun_error_flag = 1'b0;
        end
        if (s.overrun_error_flag && !s.overrun_error_flag_single &&
            !s.ctrl.continuous_receive_enable) begin
            n.overrun_error_flag = 1'b0;
        end

        // Master single receive ends after one character
        if (mode == MODE_MASTER_RX && rx_done) begin
            n.ctrl.single_receive_enable = 1'b0;
        end

        // Slave transmit shifts only on pin clocks
        if (mode == MODE_SLAVE_TX && s.ctrl.transmit_enable &&
            s.tsr_busy) begin
            if (lead) begin
                n.dout  = s.transmit_shift_register[s.tbits];
                n.tbits = s.tbits + 4'h1;
            end else if (trail && s.tbits == tx_n) begin
                // Word out: held byte moves in
                tx_done     = 1'b1;
                n.tbits     = 4'h0;
                n.transmit_shift_register       = s.hold;
                n.tsr_busy  = s.hold_full;
                n.hold_full = 1'b0;
            end
        end

        // Write commit once address and data are both in
        wr_go = n.aw_full && n.w_full && !s.bvalid;
        if (wr_go) begin
            wa        = n.awaddr;
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            case (wa)
                ADDR_CTRL: begin
                    if (n.wstrb[0]) begin
                        n.ctrl[7:0] = n.wdata[7:0];
                    end
                    if (n.wstrb[1]) begin
                        n.ctrl[11:8] = n.wdata[11:8];
                    end
                end
                ADDR_TXDATA: begin
                    wr_tx = n.wstrb[0];
                end
                ADDR_STATUS, ADDR_RXDATA: ;
                default: n.bresp = RESP_SLVERR;
            endcase
        end

        // Transmit data write: empty shift register loads at once
        if (wr_tx) begin
            if (!n.tsr_busy) begin
                n.transmit_shift_register      = {s.ctrl.transmit_ninth_bit, n.wdata[7:0]};
                n.tsr_busy = 1'b1;
                n.tbits    = 4'h0;
            end else if (!n.hold_full) begin
                // Second word waits, flag clears
                n.hold      = {s.ctrl.transmit_ninth_bit, n.wdata[7:0]};
                n.hold_full = 1'b1;
            end
        end

        // Port disable resets FIFO, overrun, receive and transmit state
        if (!n.ctrl.serial_port_enable) begin
            n.fcnt      = 2'h0;
            n.head      = 1'b0;
            n.overrun_error_flag      = 1'b0;
            n.rbits     = 4'h0;
            n.tsr_busy  = 1'b0;
            n.hold_full = 1'b0;
            n.tbits     = 4'h0;
            n.dout      = 1'b0;
        end

        // Pin drivers: slave never drives clock
        n.pins.shift_clock_out = n.mclk;
        n.pins.shift_clock_oe  = n.ctrl.serial_port_enable &
                                 n.ctrl.mode_select &
                                 n.ctrl.clock_source_select;
        n.pins.serial_data_out = n.dout;
        n.pins.serial_data_oe  = (mode == MODE_SLAVE_TX) &
                                 n.ctrl.transmit_enable &
                                 n.pins.shift_clock_oe == 1'b0;

        // Interrupt request, also the wake source
        n.irq = ((n.fcnt != 2'h0) &
                 n.ctrl.receive_interrupt_enable) |
                (~n.hold_full & n.ctrl.transmit_enable &
                 n.ctrl.transmit_interrupt_enable);

        // Channel readiness for the next cycle
        n.aw_rdy = ~n.aw_full;
        n.w_rdy  = ~n.w_full;
        n.ar_rdy = ~n.rvalid;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s.aw_rdy;
    assign s_axi_wready  = s.w_rdy;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.ar_rdy;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign pins_o        = s.pins;
    assign irq           = s.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_fifo_bound: assert property (s.fcnt <= FIFO_DEPTH)
        else $error("receive FIFO holds more than two");
    chk_overrun_set: assert property (
        rx_done && s.fcnt == FIFO_DEPTH && !pop && s.ctrl.serial_port_enable
        |=> s.overrun_error_flag && s.fcnt == FIFO_DEPTH)
        else $error("third character did not set overrun");
    chk_overrun_keep: assert property (
        s.overrun_error_flag && !pop && s.ctrl.serial_port_enable ##1
        s.ctrl.serial_port_enable |-> $stable(s.fifo) && $stable(s.fcnt))
        else $error("FIFO changed during overrun");
    chk_single_clear: assert property (
        s.overrun_error_flag && s.overrun_error_flag_single && pop |=> !s.overrun_error_flag)
        else $error("single-mode overrun not cleared by read");
    chk_cont_clear: assert property (
        s.overrun_error_flag && !s.overrun_error_flag_single && !s.ctrl.continuous_receive_enable
        |=> !s.overrun_error_flag)
        else $error("continuous overrun not cleared");
    chk_rx_flag: assert property (
        s.fcnt != 2'h0 && s.ctrl.receive_interrupt_enable
        && !pop |=> irq)
        else $error("receive request dropped with data held");
    chk_slave_ck_off: assert property (
        !s.ctrl.clock_source_select |-> !pins_o.shift_clock_oe)
        else $error("slave drives the clock pin");
    chk_single_done: assert property (
        mode == MODE_MASTER_RX && rx_done
        |=> !s.ctrl.single_receive_enable || s.bvalid)
        else $error("single receive not cleared");
    chk_tx_reload: assert property (
        tx_done && s.hold_full |=> s.tsr_busy && !s.hold_full)
        else $error("held byte not moved to shift register");
    chk_sleep_stop: assert property (
        mode == MODE_MASTER_RX && s.ctrl.sleep_mode
        |=> $stable(s.mclk))
        else $error("master clock runs in sleep");
    chk_second_held: assert property (
        wr_tx && s.tsr_busy && !tx_done && !s.hold_full
        && s.ctrl.serial_port_enable |=> s.hold_full [*2])
        else $error("second word not held");

    cov_overrun: cover property (rx_done && s.fcnt == FIFO_DEPTH && !pop);
    cov_sleep_rx: cover property (s.ctrl.sleep_mode && rx_done &&
                                  mode == MODE_SLAVE_RX);
    cov_tx_reload: cover property (tx_done && s.hold_full);
    cov_nine_bit: cover property (rx_done &&
                                  s.ctrl.ninth_bit_receive_enable);
endmodule
`default_nettype wire

// ---- dv/serial_master_model.sv ----
// Behavioural external master that clocks the slave port
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
    output logic      shift_clock_pin,
    output logic      serial_data_pin,
    input  wire logic dev_data
);
    logic [8:0] got;  // Bits read back from the slave
    initial begin
        shift_clock_pin = 1'b0;
        serial_data_pin = 1'b0;
        got = 9'h000;
    end
    // One frame, LSB first, only n clocks; clock idles low
    task automatic xfer(input logic [8:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            shift_clock_pin = 1'b1;
            serial_data_pin = w[i];
            #62;
            shift_clock_pin = 1'b0;
            got[i] = dev_data;
            #63;
        end
        serial_data_pin = ~serial_data_pin;  // Released line wanders
    endtask
endmodule
`default_nettype wire

// ---- dv/sync_serial_rx_slave_sleep_tb_top.sv ----
// Testbench for the synchronous serial port
`timescale 1ns/1ns
`default_nettype none
module sync_serial_rx_slave_sleep_tb_top;
    import sync_serial_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, irq, m_clk, m_dat, dl;
    pins_in_t pins;
    pins_out_t po;
    int errors = 0, n_compared = 0;
    // Data line: device wins while it drives
    assign dl = po.serial_data_oe ? po.serial_data_out : m_dat;
    assign pins = {m_clk, dl};
    sync_serial_rx_slave_sleep i_sync_serial_rx_slave_sleep (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(d), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pins_i(pins), .pins_o(po), .irq(irq));
    serial_master_model i_serial_master_model (
        .shift_clock_pin(m_clk), .serial_data_pin(m_dat), .dev_data(dl));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Compare one value
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Write one register
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    // Read one register, mask, compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(d & m, e);
    endtask
    task automatic print_verdict;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        print_verdict;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(ADDR_CTRL, 32'hffffffff, 32'h0);
        rdc(8'h40, 32'hffffffff, 32'h0);
        chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h0);
        chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
        rdc(ADDR_STATUS, 32'h4, 32'h0);
        // Slave receive asleep, three characters overrun
        wr(ADDR_CTRL, 32'ha13);
        i_serial_master_model.xfer(9'h0a5, 8);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, po.shift_clock_oe}, 32'h0);
        i_serial_master_model.xfer(9'h03c, 8);
        i_serial_master_model.xfer(9'h081, 8);
        rdc(ADDR_STATUS, 32'h67, 32'h45);
        rdc(ADDR_RXDATA, 32'hff, 32'ha5);
        rdc(ADDR_STATUS, 32'h67, 32'h25);
        rdc(ADDR_RXDATA, 32'hff, 32'h3c);
        wr(ADDR_CTRL, 32'ha03);
        rdc(ADDR_STATUS, 32'h65, 32'h0);
        // Nine-bit character
        wr(ADDR_CTRL, 32'h233);
        i_serial_master_model.xfer(9'h1c3, 9);
        rdc(ADDR_STATUS, 32'h6, 32'h6);
        rdc(ADDR_RXDATA, 32'hff, 32'hc3);
        // Slave transmit of two words in sleep
        wr(ADDR_CTRL, 32'hc43);
        wr(ADDR_TXDATA, 32'h5a);
        wr(ADDR_TXDATA, 32'h96);
        rdc(ADDR_STATUS, 32'h8, 32'h0);
        i_serial_master_model.xfer(9'h0, 8);
        chk({24'h0, i_serial_master_model.got[7:0]}, 32'h5a);
        rdc(ADDR_STATUS, 32'h8, 32'h8);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_TXDATA, 32'h11);
        rdc(ADDR_STATUS, 32'h8, 32'h0);
        i_serial_master_model.xfer(9'h0, 8);
        chk({24'h0, i_serial_master_model.got[7:0]}, 32'h96);
        // Master receive: idle setup, frozen asleep, then one character
        wr(ADDR_CTRL, 32'h207);
        wr(ADDR_CTRL, 32'ha0f);
        repeat (150) @(posedge aclk);
        chk({30'h0, po.shift_clock_oe, po.shift_clock_out}, 32'h2);
        rdc(ADDR_STATUS, 32'h64, 32'h0);
        wr(ADDR_CTRL, 32'h20f);
        repeat (8) @(posedge aclk);
        chk({31'h0, po.shift_clock_out}, 32'h1);
        repeat (150) @(posedge aclk);
        rdc(ADDR_STATUS, 32'h64, 32'h24);
        rdc(ADDR_CTRL, 32'h8, 32'h0);
        // Data line left high by the partner model
        rdc(ADDR_RXDATA, 32'hff, 32'hff);
        print_verdict;
    end
endmodule
`default_nettype wire
